// >>> cgr_defines.vh
// constants for the codec gain and routing register bank
// assumes an apb slave with 32-bit data, byte addresses, one word per register
// Summary of operation
// - adc gain code 0 is 0 dB, each code step adds 1.5 dB; low five ones mute.
// - dac gain code 0 is 0 dB, each step adds 1.5 dB attenuation.
// - dac codes above -36 dB group give -42, -48, -54 dB; low five ones mute.
// - sidetone bits 5..3 analog gain, 000 is -9 dB, -3 dB steps, 111 mutes.
// - sidetone bits 2..0 digital gain, 000 is -9 dB, -3 dB steps, 111 mutes.
// - speaker gain bits 5..4 give 0 to 3 dB, reset 00.
// - input routing bit 6 loops headset input to headset output, reset 0.
// - input routing bit 5 loops handset input to handset output, reset 0.
// - input routing bit 4 routes caller id input to adc, reset 0.
// - input routing bit 3 routes line input to adc, reset 0.
// - input routing bit 2 routes microphone to adc, reset 0.
// - input routing bit 1 routes handset input to adc, reset 0.
// - input routing bit 0 routes headset input to adc, reset 0.
// - output routing bits 3..0 send dac to speaker, line, handset, headset.
// - output routing bit 5 sidetone to headset, bit 4 to handset, reset 0.
`ifndef CGR_DEFINES_VH
`define CGR_DEFINES_VH

// ****************************************
// addresses
// ****************************************
`define CGR_ADDR_GAIN 12'h000
`define CGR_ADDR_ROUTE 12'h004
`define CGR_ADDR_ADC 12'h008
`define CGR_ADDR_READ_DAC 12'h00C
`define CGR_ADDR_READ_SIDE 12'h010
`define CGR_ADDR_READ_SPK 12'h014
`define CGR_ADDR_READ_IN 12'h018
`define CGR_ADDR_READ_OUT 12'h01C

// ****************************************
// selector codes
// ****************************************
`define CGR_SEL_DAC 2'b01
`define CGR_SEL_SIDE 2'b10
`define CGR_SEL_SPK 2'b11
`define CGR_SEL_ADC 2'b00

// ****************************************
// field masks and resets
// ****************************************
`define CGR_MASK_GAIN6 8'h3F
`define CGR_MASK_SIDE 8'h3F
`define CGR_MASK_SPK 8'h30
`define CGR_MASK_IN 8'h7F
`define CGR_MASK_OUT 8'h3F
`define CGR_RESET_BYTE 8'h00
`define CGR_MUTE5 5'h1F
`define CGR_MUTE3 3'h7

`endif

// >>> cgr_host.sv
// apb host model for the codec bank
// assumes the slave may stretch access with pready
`timescale 1ns/1ps
`default_nettype none
module cgr_host (
    input wire logic pclk, pready, pslverr,
    input wire logic [31:0] prdata,
    output logic psel, penable, pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // entered after a rising edge; one idle edge at the end so calls never collide
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [32:0] r);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
endmodule // cgr_host
`default_nettype wire

// >>> cgr_regs.v
// codec gain and routing register bank behind an apb slave
// assumes pclk 25 MHz, apb master from same domain, outputs feed analog front end
`timescale 1ns/1ps
`default_nettype none
`include "cgr_defines.vh"

module cgr_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    output reg [5:0] adc_gain_code,
    output reg [5:0] dac_gain_code,
    output reg dac_mute,
    output reg adc_mute,
    output reg [2:0] analog_sidetone_gain,
    output reg analog_sidetone_mute,
    output reg [2:0] digital_sidetone_gain,
    output reg digital_sidetone_mute,
    output reg [1:0] speaker_gain,
    output reg headset_loop_through,
    output reg handset_loop_through,
    output reg callerid_to_adc,
    output reg line_in_to_adc,
    output reg microphone_to_adc,
    output reg handset_in_to_adc,
    output reg headset_in_to_adc,
    output reg sidetone_to_headset,
    output reg sidetone_to_handset,
    output reg dac_to_speaker,
    output reg dac_to_line_out,
    output reg dac_to_handset_out,
    output reg dac_to_headset_out
);

    // ****************************************
    // bus decode
    // ****************************************
    wire wr_en;
    wire rd_hit;
    wire [7:0] wbyte;
    wire [1:0] sel;
    wire gain_wr;
    wire route_wr;
    wire adc_wr;
    reg [7:0] adc_gain_reg;
    reg [7:0] dac_gain_reg;
    reg [7:0] sidetone_gain_reg;
    reg [7:0] speaker_gain_reg;
    reg [7:0] input_route_reg;
    reg [7:0] output_route_reg;
    reg [7:0] next_rdata;
    reg known;
    wire adc_load;
    wire dac_load;
    wire side_load;
    wire spk_load;
    wire in_load;
    wire out_load;
    reg [7:0] next_adc_gain;
    reg [7:0] next_dac_gain;
    reg [7:0] next_side_gain;
    reg [7:0] next_spk_gain;
    reg [7:0] next_in_route;
    reg [7:0] next_out_route;
    wire [7:0] rd_adc;
    wire [7:0] rd_dac;
    wire [7:0] rd_side;
    wire [7:0] rd_spk;
    wire [7:0] rd_in;
    wire [7:0] rd_out;

    // ****************************************
    // apb handshake and word decode
    // ****************************************
    // unmapped words answer with an error but never stall
    // zero wait states keep the slave trivially predictable
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign wbyte = pwdata[7:0];
    assign sel = wbyte[7:6];
    assign gain_wr = wr_en & (paddr == `CGR_ADDR_GAIN);
    assign route_wr = wr_en & (paddr == `CGR_ADDR_ROUTE);
    // adc gain shares selector 00 with no other, so it has its own word
    assign adc_wr = wr_en & (paddr == `CGR_ADDR_ADC);
    assign rd_hit = psel & ~pwrite;
    assign pslverr = psel & penable & ~known;

    // ****************************************
    // sub-register write strobes
    // ****************************************
    // only the sub-register named by the selector bits may load, except adc gain, which also loads from its own word
    // the gain port splits on d7..d6, the route port on d7 alone
    assign adc_load = adc_wr | (gain_wr & (sel == `CGR_SEL_ADC));
    assign dac_load = gain_wr & (sel == `CGR_SEL_DAC);
    assign side_load = gain_wr & (sel == `CGR_SEL_SIDE);
    assign spk_load = gain_wr & (sel == `CGR_SEL_SPK);
    assign in_load = route_wr & ~wbyte[7];
    assign out_load = route_wr & wbyte[7];

    // ****************************************
    // sub-register storage
    // ****************************************
    // selector bits are not stored; masks drop reserved bits at the door
    // a write to an unmapped or readback word loads nothing
    // adc gain, from the direct word or selector 00
    always @* begin
        next_adc_gain = adc_gain_reg;
        if (adc_load) begin
            next_adc_gain = wbyte & `CGR_MASK_GAIN6;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_gain_reg <= `CGR_RESET_BYTE;
        end else begin
            adc_gain_reg <= next_adc_gain;
        end
    end

    // dac gain, selector 01
    always @* begin
        next_dac_gain = dac_gain_reg;
        if (dac_load) begin
            next_dac_gain = wbyte & `CGR_MASK_GAIN6;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_gain_reg <= `CGR_RESET_BYTE;
        end else begin
            dac_gain_reg <= next_dac_gain;
        end
    end

    // analog and digital sidetone, selector 10
    always @* begin
        next_side_gain = sidetone_gain_reg;
        if (side_load) begin
            next_side_gain = wbyte & `CGR_MASK_SIDE;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sidetone_gain_reg <= `CGR_RESET_BYTE;
        end else begin
            sidetone_gain_reg <= next_side_gain;
        end
    end

    // speaker gain, selector 11
    always @* begin
        next_spk_gain = speaker_gain_reg;
        if (spk_load) begin
            next_spk_gain = wbyte & `CGR_MASK_SPK;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speaker_gain_reg <= `CGR_RESET_BYTE;
        end else begin
            speaker_gain_reg <= next_spk_gain;
        end
    end

    // input routing, route port with d7 clear
    always @* begin
        next_in_route = input_route_reg;
        if (in_load) begin
            next_in_route = wbyte & `CGR_MASK_IN;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_route_reg <= `CGR_RESET_BYTE;
        end else begin
            input_route_reg <= next_in_route;
        end
    end

    // output routing, route port with d7 set
    always @* begin
        next_out_route = output_route_reg;
        if (out_load) begin
            next_out_route = wbyte & `CGR_MASK_OUT;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_route_reg <= `CGR_RESET_BYTE;
        end else begin
            output_route_reg <= next_out_route;
        end
    end

    // ****************************************
    // readback words
    // ****************************************
    assign rd_adc = adc_gain_reg;
    assign rd_dac = {`CGR_SEL_DAC, dac_gain_reg[5:0]};
    assign rd_side = {`CGR_SEL_SIDE, sidetone_gain_reg[5:0]};
    assign rd_spk = {`CGR_SEL_SPK, speaker_gain_reg[5:0]};
    // d7 reads back as the input selector, zero
    assign rd_in = input_route_reg;
    // reserved bit 6 always reads zero
    assign rd_out = {1'b1, 1'b0, output_route_reg[5:0]};

    // ****************************************
    // readback, selector bits reinserted
    // ****************************************
    always @* begin
        known = 1'b1;
        next_rdata = 8'h00;
        case (paddr)
            `CGR_ADDR_GAIN: next_rdata = 8'h00;
            `CGR_ADDR_ROUTE: next_rdata = 8'h00;
            `CGR_ADDR_ADC: next_rdata = rd_adc;
            `CGR_ADDR_READ_DAC: next_rdata = rd_dac;
            `CGR_ADDR_READ_SIDE: next_rdata = rd_side;
            `CGR_ADDR_READ_SPK: next_rdata = rd_spk;
            `CGR_ADDR_READ_IN: next_rdata = rd_in;
            `CGR_ADDR_READ_OUT: next_rdata = rd_out;
            default: known = 1'b0;
        endcase
    end

    // read data registered in the setup cycle, valid in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_hit & ~penable) begin
            prdata <= {24'h00_0000, next_rdata};
        end
    end

    // ****************************************
    // front end settings
    // ****************************************
    // every setting is a flop so the analog side never sees decode glitches
    // adc gain and its mute code
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_gain_code <= 6'h00;
            adc_mute <= 1'b0;
        end else begin
            adc_gain_code <= adc_gain_reg[5:0];
            adc_mute <= adc_gain_reg[4:0] == `CGR_MUTE5;
        end
    end

    // dac gain and its mute code
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_gain_code <= 6'h00;
            dac_mute <= 1'b0;
        end else begin
            dac_gain_code <= dac_gain_reg[5:0];
            // low five ones mute; codes just below give -42/-48/-54 dB
            dac_mute <= dac_gain_reg[4:0] == `CGR_MUTE5;
        end
    end

    // analog and digital sidetone
    // code 111 in either field mutes that path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_sidetone_gain <= 3'h0;
            analog_sidetone_mute <= 1'b0;
            digital_sidetone_gain <= 3'h0;
            digital_sidetone_mute <= 1'b0;
        end else begin
            analog_sidetone_gain <= sidetone_gain_reg[5:3];
            analog_sidetone_mute <= sidetone_gain_reg[5:3] == `CGR_MUTE3;
            digital_sidetone_gain <= sidetone_gain_reg[2:0];
            digital_sidetone_mute <= sidetone_gain_reg[2:0] == `CGR_MUTE3;
        end
    end

    // speaker gain; the low nibble is reserved and never stored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speaker_gain <= 2'h0;
        end else begin
            speaker_gain <= speaker_gain_reg[5:4];
        end
    end

    // input routing: loop-through bits bypass the adc,
    // the rest choose which inputs reach it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            headset_loop_through <= 1'b0;
            handset_loop_through <= 1'b0;
            callerid_to_adc <= 1'b0;
            line_in_to_adc <= 1'b0;
            microphone_to_adc <= 1'b0;
            handset_in_to_adc <= 1'b0;
            headset_in_to_adc <= 1'b0;
        end else begin
            headset_loop_through <= input_route_reg[6];
            handset_loop_through <= input_route_reg[5];
            callerid_to_adc <= input_route_reg[4];
            line_in_to_adc <= input_route_reg[3];
            microphone_to_adc <= input_route_reg[2];
            handset_in_to_adc <= input_route_reg[1];
            headset_in_to_adc <= input_route_reg[0];
        end
    end

    // output routing: sidetone and dac destinations
    // bit 6 is reserved, only 5..0 reach the switches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sidetone_to_headset <= 1'b0;
            sidetone_to_handset <= 1'b0;
            dac_to_speaker <= 1'b0;
            dac_to_line_out <= 1'b0;
            dac_to_handset_out <= 1'b0;
            dac_to_headset_out <= 1'b0;
        end else begin
            sidetone_to_headset <= output_route_reg[5];
            sidetone_to_handset <= output_route_reg[4];
            dac_to_speaker <= output_route_reg[3];
            dac_to_line_out <= output_route_reg[2];
            dac_to_handset_out <= output_route_reg[1];
            dac_to_headset_out <= output_route_reg[0];
        end
    end

endmodule // cgr_regs
`default_nettype wire

// >>> cgr_regs_assertions.sv
// assertions for the codec gain and routing bank
// assumes zero-wait apb; settings follow one edge after a write
`timescale 1ns/1ps
`default_nettype none
module cgr_regs_chk (
    input wire pclk, presetn, psel, penable, pwrite, pready, dac_mute,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [5:0] adc_gain_code, dac_gain_code,
    input wire [2:0] analog_sidetone_gain, digital_sidetone_gain,
    input wire [1:0] speaker_gain,
    input wire headset_loop_through, headset_in_to_adc, sidetone_to_headset, dac_to_headset_out
);
    wire wg = psel & penable & pwrite & (paddr == 12'h000);
    wire wt = psel & penable & pwrite & (paddr == 12'h004);
    wire [1:0] sl = pwdata[7:6];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // register loads at the write edge, the setting one edge later
    chk_adc_gain: assert property (wg && sl == 2'b00 |=> ##1
        adc_gain_code == $past(pwdata[5:0], 2)) else $error("adc gain");
    chk_dac_gain: assert property (wg && sl == 2'b01 |=> ##1
        dac_gain_code == $past(pwdata[5:0], 2)) else $error("dac gain");
    chk_dac_mute: assert property (dac_mute == (dac_gain_code[4:0] == 5'h1F))
        else $error("dac mute");
    chk_side_gain: assert property (wg && sl == 2'b10 |=> ##1
        {analog_sidetone_gain, digital_sidetone_gain} == $past(pwdata[5:0], 2))
        else $error("sidetone");
    chk_spk_gain: assert property (wg && sl == 2'b11 |=> ##1
        speaker_gain == $past(pwdata[5:4], 2)) else $error("speaker");
    chk_in_route: assert property (wt && !pwdata[7] |=> ##1
        {headset_loop_through, headset_in_to_adc} == {$past(pwdata[6], 2), $past(pwdata[0], 2)})
        else $error("input route");
    chk_out_route: assert property (wt && pwdata[7] |=> ##1
        {sidetone_to_headset, dac_to_headset_out} == {$past(pwdata[5], 2), $past(pwdata[0], 2)})
        else $error("output route");
    chk_only_sel: assert property (!wg |=> ##1 $stable({dac_gain_code, speaker_gain,
        analog_sidetone_gain, digital_sidetone_gain})) else $error("stray update");
    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("wait state");
    cover property (wg && sl == 2'b01);
    cover property (wt && pwdata[7]);
    cover property (wg && sl == 2'b11);
endmodule // cgr_regs_chk
bind cgr_regs cgr_regs_chk cgr_regs_chk_i (.*);
`default_nettype wire

// >>> cgr_regs_tb_top.sv
// bench for the codec gain and routing bank
// assumes cgr_host drives apb; a byte shadow gives expectations
`timescale 1ns/1ps
`default_nettype none
module cgr_regs_tb_top;
    logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, dac_mute, adc_mute;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] adc_gain_code, dac_gain_code;
    logic [2:0] analog_sidetone_gain, digital_sidetone_gain;
    logic [1:0] speaker_gain;
    logic analog_sidetone_mute, digital_sidetone_mute, headset_loop_through, handset_loop_through;
    logic callerid_to_adc, line_in_to_adc, microphone_to_adc, handset_in_to_adc, headset_in_to_adc;
    logic sidetone_to_headset, sidetone_to_handset, dac_to_speaker, dac_to_line_out;
    logic dac_to_handset_out, dac_to_headset_out;
    logic [32:0] r;
    // shadow holds the expected readback byte of adc, dac, sidetone, speaker, in, out
    logic [7:0] sh [0:5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h00, 8'h80};
    logic [7:0] mk [0:5] = '{8'h3F, 8'hFF, 8'hFF, 8'hF0, 8'hFF, 8'hBF};
    logic [19:0] cb [0:7] = '{20'h0_001F, 20'h0_005F, 20'h0_005E, 20'h0_00BF, 20'h0_00B6,
        20'h0_00FF, 20'h0_047F, 20'h0_04FF};
    int failures = 0, n_checks = 0, cyc = 0;
    cgr_regs cgr_regs_i (.*);
    cgr_host cgr_host_i (.*);
    initial forever #20 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 10000) begin
        failures++;
        end_sim();
    end
    task automatic end_sim();
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [36:0] exp_out();
        return {sh[0][5:0], sh[1][5:0], &sh[1][4:0], &sh[0][4:0], sh[2][5:3], &sh[2][5:3],
            sh[2][2:0], &sh[2][2:0], sh[3][5:4], sh[4][6:0], sh[5][5:0]};
    endfunction
    task automatic check_all();
        // settings move one edge after the write edge; look once they settle
        @(posedge pclk);
        cmp({adc_gain_code, dac_gain_code, dac_mute, adc_mute, analog_sidetone_gain,
            analog_sidetone_mute, digital_sidetone_gain, digital_sidetone_mute, speaker_gain,
            headset_loop_through, handset_loop_through, callerid_to_adc, line_in_to_adc,
            microphone_to_adc, handset_in_to_adc, headset_in_to_adc, sidetone_to_headset,
            sidetone_to_handset, dac_to_speaker, dac_to_line_out, dac_to_handset_out,
            dac_to_headset_out}, exp_out());
        for (int i = 0; i < 6; i++) begin
            cgr_host_i.xfer(1'b0, 12'(8 + 4 * i), 32'h0, r);
            cmp(r, {25'h0, sh[i]});
        end
    endtask
    // upper data bits are random junk: only the low byte may count
    task automatic wr(input logic [11:0] a, input logic [7:0] b);
        int i;
        i = a == 12'h000 ? b[7:6] : a == 12'h004 ? 4 + b[7] : a == 12'h008 ? 0 : -1;
        cgr_host_i.xfer(1'b1, a, ($urandom & 32'hFFFF_FF00) | b, r);
        if (i >= 0)
            sh[i] = b & mk[i];
        cmp(r[32], a > 12'h01C);
    endtask
    initial begin
        void'($urandom(89632));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_all();
        foreach (cb[k]) begin
            wr(cb[k][19:8], cb[k][7:0]);
            check_all();
        end
        wr(12'h00C, 8'h41);
        wr(12'h020, 8'hFF);
        cgr_host_i.xfer(1'b0, 12'h020, 32'h0, r);
        cmp(r, 33'h1_0000_0000);
        repeat (60) begin
            wr(12'(4 * ($urandom % 3)), 8'($urandom));
            check_all();
        end
        end_sim();
    end
endmodule // cgr_regs_tb_top
`default_nettype wire
